// *** src/meil_pkg.sv ***
// package: register map, field layout and carriers for the motion event latch
package meil_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TILT_POSITION_NOW_ADDR       = 8'h14;
  localparam logic [7:0] TILT_POSITION_PREV_ADDR      = 8'h15;
  localparam logic [7:0] TAP_DIRECTION_SOURCE_ADDR    = 8'h16;
  localparam logic [7:0] FUNCTION_EVENT_SOURCE_ADDR   = 8'h17;
  localparam logic [7:0] WAKE_DIRECTION_SOURCE_ADDR   = 8'h18;
  localparam logic [7:0] INTERRUPT_SUMMARY_ADDR       = 8'h19;
  localparam logic [7:0] INTERRUPT_LATCH_RELEASE_ADDR = 8'h1A;
  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [5:0] ORIENT_RESET      = 6'h20;
  localparam logic       WAKE_STATE_RESET  = 1'b1;
  localparam int         FREEFALL_BIT      = 7;
  localparam int         BUFFER_FULL_BIT   = 6;
  localparam int         WATERMARK_BIT     = 5;
  localparam int         DATA_READY_BIT    = 4;
  localparam int         TILT_CHANGED_BIT  = 0;
  localparam int         SUMMARY_INT_BIT   = 4;
  localparam int         WAKEUP_BIT        = 7;
  localparam int         BACK_TO_SLEEP_BIT = 6;
  localparam logic [1:0] TAP_NONE   = 2'h0;
  localparam logic [1:0] TAP_SINGLE = 2'h1;
  localparam logic [1:0] TAP_DOUBLE = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  // six direction bits: x-, x+, y-, y+, z-, z+ from bit 5 down to 0
  typedef struct packed {
    logic x_neg;
    logic x_pos;
    logic y_neg;
    logic y_pos;
    logic z_neg;
    logic z_pos;
  } meil_dir_s;

  // events from the detection engines, one-cycle pulses except noted levels
  typedef struct packed {
    logic       tilt_update;    // tilt engine odr tick
    meil_dir_s  tilt_orient;    // orientation sampled on tilt_update
    logic       tap_update;     // tap engine odr tick
    meil_dir_s  tap_dir;
    logic [1:0] tap_kind;
    logic       freefall;
    logic       data_new;
    logic       wakeup;
    logic       back_to_sleep;
    meil_dir_s  motion_dir;
    logic       buffer_full;    // level from buffer logic
    logic       watermark;      // level from buffer logic
    logic       int_enabled_any; // or of enabled live sources
  } meil_events_s;

  // register bus toward the serial interface
  typedef struct packed {
    logic       rd;         // one-cycle read strobe
    logic [7:0] addr;
    logic       burst_cont; // read is a later byte of an auto-increment burst
  } meil_rdreq_s;
endpackage : meil_pkg

// *** src/meil_dir_latch.sv ***
// sticky six-bit direction latch with set-over-clear
`timescale 1ns/10ps
`default_nettype none
module meil_dir_latch #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             clear,
  // state
  output logic      [WIDTH-1:0] value
);
  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  always_comb begin
    value_d = value_q;
    if (clear) begin
      value_d = '0;
    end
    // new events win over the clearing read
    if (load) begin
      value_d = value_d | set_bits; // see RULE22
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= '0;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;
endmodule : meil_dir_latch
`default_nettype wire

// *** src/meil_latch.sv ***
// motion event interrupt latch: orientation, source, status and release registers
// Function
// RULE1: current orientation in bits 5..0, top zero
// RULE2: previous orientation kept; both reset to left
// RULE3: source bits stay set until their clear
// RULE4: tap directions update at tap rate, release clears
// RULE5: tap bits x-,x+,y-,y+,z-,z+ from bit5
// RULE6: freefall bit7 set, release read clears
// RULE7: buffer-full bit6 follows buffer full level
// RULE8: watermark bit5 follows threshold level
// RULE9: data-ready bit4 cleared by data or release read
// RULE10: tap kind bits3..2, release read clears
// RULE11: tilt-changed bit0, bit1 reserved zero
// RULE12: wakeup bit7 set, release read clears
// RULE13: back-to-sleep bit6 set, release read clears
// RULE14: wake direction bits 5..0 axis order
// RULE15: summary bit4 is or of enabled sources
// RULE16: summary bit0 wake state, wake after reset
// RULE17: host sets manual sleep for wake-only use
// RULE18: release read returns zero, clears, drops pin
// RULE19: orientation updates at tilt rate, stable during read
// RULE20: release read leaves watermark, buffer-full alone
// RULE21: burst passing release does not clear
// RULE22: event in clearing cycle is kept
// RULE23: clear acts after read data captured
`timescale 1ns/10ps
`default_nettype none
module meil_latch (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // engine events
  input  wire meil_pkg::meil_events_s ev,
  // register read port
  input  wire meil_pkg::meil_rdreq_s  rdreq,
  input  wire logic                  reading_busy,
  output logic                       rd_valid,
  output logic [7:0]                 rd_data,
  // latched interrupt pin level, high while any latched source is set
  output logic                       int_latched
);
  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  logic release_hit;
  logic accel_hit;
  logic rel_clear_q;
  logic rel_clear_d;
  logic accel_clear_q;
  logic accel_clear_d;

  function automatic logic is_accel(input logic [7:0] a);
    is_accel = (a >= 8'h08) && (a <= 8'h0D);
  endfunction : is_accel

  // a burst passing over the release byte is an ordinary read
  assign release_hit = rdreq.rd && !rdreq.burst_cont
                     && (rdreq.addr == meil_pkg::INTERRUPT_LATCH_RELEASE_ADDR); // see RULE21
  assign accel_hit   = rdreq.rd && is_accel(rdreq.addr);

  // clears are delayed one cycle so the read sees pre-clear contents
  always_comb begin
    rel_clear_d   = release_hit;   // see RULE23
    accel_clear_d = accel_hit;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rel_clear_q   <= 1'b0;
      accel_clear_q <= 1'b0;
    end else begin
      rel_clear_q   <= rel_clear_d;
      accel_clear_q <= accel_clear_d;
    end
  end

  // ----------------------------------------------------------------------
  // orientation registers
  // ----------------------------------------------------------------------
  logic [5:0] orient_now_q;
  logic [5:0] orient_now_d;
  logic [5:0] orient_prev_q;
  logic [5:0] orient_prev_d;
  logic       tilt_pend_q;
  logic       tilt_pend_d;
  logic [5:0] tilt_hold_q;
  logic [5:0] tilt_hold_d;
  logic       tilt_apply;

  // an update that lands during a host read waits until the read is over
  assign tilt_apply = (ev.tilt_update || tilt_pend_q) && !reading_busy; // see RULE19

  always_comb begin
    orient_now_d  = orient_now_q;
    orient_prev_d = orient_prev_q;
    tilt_pend_d   = tilt_pend_q;
    tilt_hold_d   = tilt_hold_q;
    if (ev.tilt_update) begin
      tilt_hold_d = ev.tilt_orient;
      tilt_pend_d = 1'b1;
    end
    if (tilt_apply) begin
      tilt_pend_d = 1'b0;
      if ((ev.tilt_update ? ev.tilt_orient : tilt_hold_q) != orient_now_q) begin
        orient_prev_d = orient_now_q;                                     // see RULE2
        orient_now_d  = ev.tilt_update ? ev.tilt_orient : tilt_hold_q;     // see RULE1
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      orient_now_q  <= meil_pkg::ORIENT_RESET; // see RULE2
      orient_prev_q <= meil_pkg::ORIENT_RESET;
      tilt_pend_q   <= 1'b0;
      tilt_hold_q   <= meil_pkg::ORIENT_RESET;
    end else begin
      orient_now_q  <= orient_now_d;
      orient_prev_q <= orient_prev_d;
      tilt_pend_q   <= tilt_pend_d;
      tilt_hold_q   <= tilt_hold_d;
    end
  end

  // ----------------------------------------------------------------------
  // direction latches for tap and wake sources
  // ----------------------------------------------------------------------
  logic [5:0] tap_dir_val;
  logic [5:0] motion_dir_val;

  meil_dir_latch #(.WIDTH(6)) u_tap_dir (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (ev.tap_update),   // see RULE4
    .set_bits (ev.tap_dir),      // see RULE5
    .clear    (rel_clear_q),
    .value    (tap_dir_val)
  );

  meil_dir_latch #(.WIDTH(6)) u_motion_dir (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (ev.wakeup),       // see RULE14
    .set_bits (ev.motion_dir),
    .clear    (rel_clear_q),
    .value    (motion_dir_val)
  );

  // ----------------------------------------------------------------------
  // function and wake event flags
  // ----------------------------------------------------------------------
  logic       ff_q;
  logic       ff_d;
  logic       data_ready_flag_q;
  logic       data_ready_flag_d;
  logic [1:0] tapk_q;
  logic [1:0] tapk_d;
  logic       tilt_chg_q;
  logic       tilt_chg_d;
  logic       wu_q;
  logic       wu_d;
  logic       bts_q;
  logic       bts_d;
  logic       wake_q;
  logic       wake_d;
  logic       orient_changed;

  assign orient_changed = tilt_apply && (orient_now_d != orient_now_q);

  // sticky flags: the set term is applied last so it beats the clear
  always_comb begin
    ff_d       = rel_clear_q ? 1'b0 : ff_q;
    data_ready_flag_d     = (rel_clear_q || accel_clear_q) ? 1'b0 : data_ready_flag_q;  // see RULE9
    tapk_d     = rel_clear_q ? meil_pkg::TAP_NONE : tapk_q;        // see RULE10
    tilt_chg_d = rel_clear_q ? 1'b0 : tilt_chg_q;
    wu_d       = rel_clear_q ? 1'b0 : wu_q;                        // see RULE12
    bts_d      = rel_clear_q ? 1'b0 : bts_q;                       // see RULE13
    wake_d     = wake_q;
    if (ev.freefall) begin
      ff_d = 1'b1;                                                 // see RULE6
    end
    if (ev.data_new) begin
      data_ready_flag_d = 1'b1;                                               // see RULE22
    end
    if (ev.tap_update && (ev.tap_kind != meil_pkg::TAP_NONE)) begin
      tapk_d = ev.tap_kind;                                        // see RULE3
    end
    if (orient_changed) begin
      tilt_chg_d = 1'b1;                                           // see RULE11
    end
    if (ev.wakeup) begin
      wu_d   = 1'b1;
      wake_d = 1'b1;                                               // see RULE16
    end
    if (ev.back_to_sleep) begin
      bts_d  = 1'b1;
      wake_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ff_q       <= 1'b0;
      data_ready_flag_q     <= 1'b0;
      tapk_q     <= meil_pkg::TAP_NONE;
      tilt_chg_q <= 1'b0;
      wu_q       <= 1'b0;
      bts_q      <= 1'b0;
      wake_q     <= meil_pkg::WAKE_STATE_RESET;
    end else begin
      ff_q       <= ff_d;
      data_ready_flag_q     <= data_ready_flag_d;
      tapk_q     <= tapk_d;
      tilt_chg_q <= tilt_chg_d;
      wu_q       <= wu_d;
      bts_q      <= bts_d;
      wake_q     <= wake_d;
    end
  end

  // ----------------------------------------------------------------------
  // register images and read mux
  // ----------------------------------------------------------------------
  logic [7:0] func_src;
  logic [7:0] wake_src;
  logic [7:0] summary;
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;
  logic       rd_valid_q;

  // buffer flags are live levels, so a release read cannot touch them
  always_comb begin
    func_src = 8'h00; // see RULE20
    func_src[meil_pkg::FREEFALL_BIT]     = ff_q;
    func_src[meil_pkg::BUFFER_FULL_BIT]  = ev.buffer_full;  // see RULE7
    func_src[meil_pkg::WATERMARK_BIT]    = ev.watermark;    // see RULE8
    func_src[meil_pkg::DATA_READY_BIT]   = data_ready_flag_q;
    func_src[3:2]                        = tapk_q;
    func_src[meil_pkg::TILT_CHANGED_BIT] = tilt_chg_q;
    wake_src = {wu_q, bts_q, motion_dir_val};
    summary  = 8'h00;
    summary[meil_pkg::SUMMARY_INT_BIT]   = ev.int_enabled_any; // see RULE15
    summary[0]                           = wake_q;
  end

  always_comb begin
    rd_data_d = rd_data_q;
    if (rdreq.rd) begin
      case (rdreq.addr)
        meil_pkg::TILT_POSITION_NOW_ADDR:       rd_data_d = {2'h0, orient_now_q};
        meil_pkg::TILT_POSITION_PREV_ADDR:      rd_data_d = {2'h0, orient_prev_q};
        meil_pkg::TAP_DIRECTION_SOURCE_ADDR:    rd_data_d = {2'h0, tap_dir_val};
        meil_pkg::FUNCTION_EVENT_SOURCE_ADDR:   rd_data_d = func_src;
        meil_pkg::WAKE_DIRECTION_SOURCE_ADDR:   rd_data_d = wake_src;
        meil_pkg::INTERRUPT_SUMMARY_ADDR:       rd_data_d = summary;
        meil_pkg::INTERRUPT_LATCH_RELEASE_ADDR: rd_data_d = 8'h00;    // see RULE18
        default:                                rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rdreq.rd;
    end
  end

  assign rd_data     = rd_data_q;
  assign rd_valid    = rd_valid_q;
  assign int_latched = ff_q || data_ready_flag_q || (tapk_q != meil_pkg::TAP_NONE) || tilt_chg_q
                     || wu_q || bts_q || (|tap_dir_val) || (|motion_dir_val);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  release_clears_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE18
    release_hit && !ev.freefall && !$past(ev.freefall) ##1 !ev.freefall |=> !ff_q)
    else $error("freefall flag survived release read");
  release_reads_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE18
    rdreq.rd && rdreq.addr == meil_pkg::INTERRUPT_LATCH_RELEASE_ADDR |=> rd_data == 8'h00)
    else $error("release register read not zero");
  burst_no_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE21
    rdreq.rd && rdreq.burst_cont && !rel_clear_q && wu_q |=> ##1 wu_q)
    else $error("burst pass cleared wakeup flag");
  set_wins_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE22
    rel_clear_q && ev.wakeup && !ev.back_to_sleep |=> wu_q && wake_q)
    else $error("event lost in clearing cycle");
  read_before_clear_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE23
    rdreq.rd && rdreq.addr == meil_pkg::FUNCTION_EVENT_SOURCE_ADDR && ff_q
    |=> rd_data[meil_pkg::FREEFALL_BIT])
    else $error("read did not show pre-clear flag");
  orient_top_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE1
    rdreq.rd && rdreq.addr == meil_pkg::TILT_POSITION_NOW_ADDR |=> rd_data[7:6] == 2'h0)
    else $error("orientation top bits not zero");
  orient_stable_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE19
    reading_busy |=> $stable(orient_now_q) || !$past(reading_busy))
    else $error("orientation changed during read");
  sticky_flag_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE3
    bts_q && !rel_clear_q |=> bts_q)
    else $error("back to sleep flag dropped without clear");
  data_ready_flag_accel_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE9
    accel_hit && !ev.data_new ##1 !ev.data_new |=> !data_ready_flag_q)
    else $error("data ready not cleared by data read");
  summary_int_a: assert property (@(posedge clock) disable iff (!arst_n) // see RULE15
    rdreq.rd && rdreq.addr == meil_pkg::INTERRUPT_SUMMARY_ADDR
    |=> rd_data[meil_pkg::SUMMARY_INT_BIT] == $past(ev.int_enabled_any)
        && rd_data[7:5] == 3'h0 && rd_data[3:1] == 3'h0)
    else $error("summary register image wrong");
endmodule : meil_latch
`default_nettype wire

// *** testbench/meil_host_model.sv ***
// host model: reads the latch registers one byte at a time
`timescale 1ns/10ps
`default_nettype none
module meil_host_model (
  // clock
  input  wire logic                  clock,
  // register read port
  output var  meil_pkg::meil_rdreq_s rdreq,
  output var  logic                  reading_busy,
  input  wire logic                  rd_valid,
  input  wire logic [7:0]            rd_data
);
  // ----------------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------------
  initial begin
    rdreq        = '{rd: 1'b0, addr: 8'h00, burst_cont: 1'b0};
    reading_busy = 1'b0;
  end

  // ----------------------------------------------------------------------
  // one read: strobe for one cycle, answer sampled one cycle later
  // ----------------------------------------------------------------------
  // the wake-only manual sleep setting lives in a control register outside
  // this block, so the model never needs to issue it
  task automatic read_reg(input logic [7:0] addr, input logic burst,
                          output logic [7:0] data, output logic vld);
    @(negedge clock);
    rdreq        = '{rd: 1'b1, addr: addr, burst_cont: burst};
    reading_busy = 1'b1;
    @(negedge clock);
    // rd_valid stands only in the cycle after the accepting edge
    data       = rd_data;
    vld        = rd_valid;
    // released address lines show a changed pattern, not the old value
    rdreq.rd   = 1'b0;
    rdreq.addr = ~addr;
    @(negedge clock);
    reading_busy = 1'b0;
  endtask : read_reg
endmodule : meil_host_model
`default_nettype wire

// *** testbench/meil_latch_tb.sv ***
// self-checking testbench for the motion event interrupt latch
`timescale 1ns/10ps
`default_nettype none
module meil_latch_tb;
  logic                   clock;
  logic                   arst_n;
  meil_pkg::meil_events_s ev;
  meil_pkg::meil_rdreq_s  rdreq;
  logic                   reading_busy;
  logic                   rd_valid;
  logic [7:0]             rd_data;
  logic                   int_latched;
  int                     err_total;
  int                     n_compared;
  logic [7:0]             rst_addr [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h30};
  logic [7:0]             rst_exp  [8] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

  meil_latch u_dut (.clock(clock), .arst_n(arst_n), .ev(ev), .rdreq(rdreq),
    .reading_busy(reading_busy), .rd_valid(rd_valid), .rd_data(rd_data),
    .int_latched(int_latched));
  meil_host_model u_host (.clock(clock), .rdreq(rdreq), .reading_busy(reading_busy),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic burst = 1'b0);
    logic [7:0] data;
    logic       vld;
    u_host.read_reg(addr, burst, data, vld);
    check("rd_valid", 8'h01, {7'h00, vld});
    check($sformatf("register %h", addr), exp, data);
  endtask : rd

  // a release clear lands on the rising edge before the read returns; the pin is sampled at the next falling edge
  task automatic pin(input logic exp);
    @(negedge clock);
    check("int_latched", {7'h00, exp}, {7'h00, int_latched});
  endtask : pin

  // pulses last exactly one cycle; levels are left alone
  task automatic tick;
    @(negedge clock);
    ev.tilt_update   = 1'b0;
    ev.tap_update    = 1'b0;
    ev.freefall      = 1'b0;
    ev.data_new      = 1'b0;
    ev.wakeup        = 1'b0;
    ev.back_to_sleep = 1'b0;
  endtask : tick

  // ----------------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #100us;
    err_total++;
    $display("[ERR] watchdog expected done seen timeout");
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    arst_n     = 1'b0;
    ev         = '0;
    err_total  = 0;
    n_compared = 0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    for (int k = 0; k < 8; k++) rd(rst_addr[k], rst_exp[k]);
    pin(1'b0);
    ev.tilt_orient = 6'h04;
    ev.tilt_update = 1'b1;
    tick();
    rd(8'h14, 8'h04);
    rd(8'h15, 8'h20);
    rd(8'h17, 8'h01);
    pin(1'b1);
    rd(8'h1A, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h14, 8'h04);
    ev.tilt_update = 1'b1;
    tick();
    rd(8'h17, 8'h00);
    for (int k = 0; k < 6; k++) begin
      ev.tap_dir    = 6'(1 << k);
      ev.tap_kind   = meil_pkg::TAP_SINGLE;
      ev.tap_update = 1'b1;
      tick();
      rd(8'h16, 8'(1 << k));
      rd(8'h17, 8'h04);
      rd(8'h1A, 8'h00);
    end
    ev.tap_dir    = 6'h20;
    ev.tap_kind   = meil_pkg::TAP_DOUBLE;
    ev.tap_update = 1'b1;
    tick();
    rd(8'h17, 8'h08);
    pin(1'b1);
    rd(8'h1A, 8'h00);
    pin(1'b0);
    rd(8'h16, 8'h00);
    ev.freefall        = 1'b1;
    ev.data_new        = 1'b1;
    ev.wakeup          = 1'b1;
    ev.motion_dir      = 6'h12;
    ev.buffer_full     = 1'b1;
    ev.watermark       = 1'b1;
    ev.int_enabled_any = 1'b1;
    tick();
    rd(8'h17, 8'hF0);
    rd(8'h18, 8'h92);
    rd(8'h19, 8'h11);
    ev.back_to_sleep = 1'b1;
    tick();
    rd(8'h18, 8'hD2);
    rd(8'h19, 8'h10);
    rd(8'h1A, 8'h00, 1'b1);
    rd(8'h17, 8'hF0);
    rd(8'h08, 8'h00);
    rd(8'h17, 8'hE0);
    rd(8'h1A, 8'h00);
    rd(8'h17, 8'h60);
    rd(8'h18, 8'h00);
    pin(1'b0);
    ev.buffer_full     = 1'b0;
    ev.watermark       = 1'b0;
    ev.int_enabled_any = 1'b0;
    rd(8'h17, 8'h00);
    rd(8'h19, 8'h00);
    ev.data_new = 1'b1;
    tick();
    rd(8'h1A, 8'h00);
    rd(8'h17, 8'h00);
    ev.wakeup     = 1'b1;
    ev.motion_dir = 6'h01;
    tick();
    rd(8'h19, 8'h01);
    rd(8'h18, 8'h81);
    // the event overlaps the clearing read and must survive it
    fork
      rd(8'h1A, 8'h00);
      begin
        ev.freefall = 1'b1;
        ev.wakeup   = 1'b1;
        repeat (4) @(negedge clock);
        ev.freefall = 1'b0;
        ev.wakeup   = 1'b0;
      end
    join
    rd(8'h17, 8'h80);
    rd(8'h18, 8'h81);
    // orientation change while the host is reading is held back
    fork
      rd(8'h14, 8'h04);
      begin
        repeat (2) @(negedge clock);
        ev.tilt_orient = 6'h01;
        ev.tilt_update = 1'b1;
        @(negedge clock);
        ev.tilt_update = 1'b0;
      end
    join
    rd(8'h14, 8'h01);
    rd(8'h15, 8'h04);
    arst_n = 1'b0;
    tick();
    arst_n = 1'b1;
    rd(8'h14, 8'h20);
    rd(8'h19, 8'h01);
    tally_and_finish();
  end
endmodule : meil_latch_tb
`default_nettype wire
